// File: dv/spd_line_model.sv
// shared single-wire line with pull-up, attached devices and the inverting pulldown stage
module spd_line_model
(
    // pins from the driver
    input wire logic bid_o,
    input wire logic bid_oe,
    input wire logic pdir_o,
    input wire logic pdir_oe,
    input wire logic inverting_pulldown_stage,
    // a device on the line holding it low
    input wire logic dev_pull,
    // levels seen back at the driver
    output logic bid_i,
    output logic pdir_i,
    output logic fix_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic low_req;
    // wired-and: any enabled low driver, the stage or a device pulls low, else the pull-up wins
    assign low_req = (bid_oe && !bid_o) || (pdir_oe && !pdir_o) || dev_pull;
    // a high stage output makes the external transistor sink the line
    assign bid_i = !(low_req || inverting_pulldown_stage);
    assign pdir_i = bid_i;
    assign fix_i = bid_i;
endmodule

// File: dv/test_spd_top.sv
// self-checking bench for the single-wire port driver
`include "spd_defs.svh"

module test_spd_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic share_busy = 1'b0, dev_pull = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic bid_i, bid_o, bid_oe, pdir_i, pdir_o, pdir_oe, fix_i, stage, prog_en, spu_en;
    int fails = 0;
    int total_checks = 0;

    // 25 MHz core clock
    always #20 core_clk = ~core_clk;

    spd_top #(.ADDR_W(4)) u_spd_top (
        .core_clk(core_clk), .arst_n(arst_n),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .bid_i(bid_i), .bid_o(bid_o), .bid_oe(bid_oe),
        .pdir_i(pdir_i), .pdir_o(pdir_o), .pdir_oe(pdir_oe),
        .fix_i(fix_i), .inverting_pulldown_stage(stage), .share_busy(share_busy),
        .prog_supply_en(prog_en), .strong_pullup_en(spu_en));

    spd_line_model u_spd_line_model (
        .bid_o(bid_o), .bid_oe(bid_oe), .pdir_o(pdir_o), .pdir_oe(pdir_oe),
        .inverting_pulldown_stage(stage), .dev_pull(dev_pull),
        .bid_i(bid_i), .pdir_i(pdir_i), .fix_i(fix_i));

    // prints counts and verdict, ends the run
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // compares one value
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one write transfer, address and data offered together
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge core_clk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                chk("bresp", {30'h0, bresp}, {30'h0, er});
                return;
            end
        end
        fails++;
        conclude();
    endtask

    // one read transfer
    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge core_clk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                chk("rresp", {30'h0, rresp}, {30'h0, er});
                chk("rdata", rdata, ed);
                return;
            end
        end
        fails++;
        conclude();
    endtask

    // lets pin outputs and the sampled level settle, then checks pin enables
    task automatic pins(input logic [2:0] exp);
        repeat (3) @(posedge core_clk);
        chk("pin enables", {29'h0, bid_oe, pdir_oe, stage}, {29'h0, exp});
        chk("data latches", {30'h0, bid_o, pdir_o}, 32'h0);
    endtask

    // reset values, unmapped offset
    task automatic t_reset();
        pins(3'b000);
        chk("readies", {29'h0, awready, wready, arready}, 32'h7);
        rd(`SPD_ADDR_CTRL, 32'h0, `SPD_RESP_OKAY);
        rd(`SPD_ADDR_LINE, 32'h3, `SPD_RESP_OKAY);
        rd(`SPD_ADDR_AUX, 32'h0, `SPD_RESP_OKAY);
        rd(4'hc, 32'h0, `SPD_RESP_DECERR);
        wr(4'hc, 32'h0, `SPD_RESP_DECERR);
        pins(3'b000);
    endtask

    // bidirectional pin: drive low, release, sense a device pulling low
    task automatic t_bidir();
        wr(`SPD_ADDR_CTRL, 32'h0, `SPD_RESP_OKAY);
        wr(`SPD_ADDR_LINE, 32'h0, `SPD_RESP_OKAY);
        pins(3'b100);
        rd(`SPD_ADDR_LINE, 32'h0, `SPD_RESP_OKAY);
        wr(`SPD_ADDR_LINE, 32'h1, `SPD_RESP_OKAY);
        dev_pull <= 1'b1;
        pins(3'b000);
        rd(`SPD_ADDR_LINE, 32'h1, `SPD_RESP_OKAY);
        dev_pull <= 1'b0;
        pins(3'b000);
        rd(`SPD_ADDR_LINE, 32'h3, `SPD_RESP_OKAY);
    endtask

    // programmable direction, both polarities, sampling through the pin
    task automatic t_pdir();
        int p;
        for (p = 0; p < 2; p++) begin
            wr(`SPD_ADDR_CTRL, 32'h1 | (p << 2), `SPD_RESP_OKAY);
            wr(`SPD_ADDR_LINE, 32'h0, `SPD_RESP_OKAY);
            pins(3'b010);
            rd(`SPD_ADDR_LINE, 32'h0, `SPD_RESP_OKAY);
            wr(`SPD_ADDR_LINE, 32'h1, `SPD_RESP_OKAY);
            dev_pull <= 1'b1;
            pins(3'b000);
            rd(`SPD_ADDR_LINE, 32'h1, `SPD_RESP_OKAY);
            dev_pull <= 1'b0;
        end
    endtask

    // fixed pair through the inverting stage, then the off setting
    task automatic t_fixed();
        wr(`SPD_ADDR_CTRL, 32'h2, `SPD_RESP_OKAY);
        wr(`SPD_ADDR_LINE, 32'h0, `SPD_RESP_OKAY);
        pins(3'b001);
        rd(`SPD_ADDR_LINE, 32'h0, `SPD_RESP_OKAY);
        wr(`SPD_ADDR_LINE, 32'h1, `SPD_RESP_OKAY);
        dev_pull <= 1'b1;
        pins(3'b000);
        rd(`SPD_ADDR_LINE, 32'h1, `SPD_RESP_OKAY);
        dev_pull <= 1'b0;
        wr(`SPD_ADDR_CTRL, 32'h3, `SPD_RESP_OKAY);
        wr(`SPD_ADDR_LINE, 32'h0, `SPD_RESP_OKAY);
        pins(3'b000);
        rd(`SPD_ADDR_LINE, 32'h2, `SPD_RESP_OKAY);
    endtask

    // shared pin yields the line while the other peripheral is busy
    task automatic t_shared();
        share_busy <= 1'b1;
        wr(`SPD_ADDR_CTRL, 32'h8, `SPD_RESP_OKAY);
        rd(`SPD_ADDR_CTRL, 32'h8, `SPD_RESP_OKAY);
        pins(3'b000);
        share_busy <= 1'b0;
        pins(3'b100);
        wr(`SPD_ADDR_LINE, 32'h1, `SPD_RESP_OKAY);
        pins(3'b000);
    endtask

    // supply controls and their interlock
    task automatic t_aux();
        wr(`SPD_ADDR_AUX, 32'h2, `SPD_RESP_OKAY);
        pins(3'b000);
        chk("supplies", {30'h0, prog_en, spu_en}, 32'h1);
        rd(`SPD_ADDR_AUX, 32'h2, `SPD_RESP_OKAY);
        wr(`SPD_ADDR_AUX, 32'h1, `SPD_RESP_OKAY);
        pins(3'b000);
        chk("supplies", {30'h0, prog_en, spu_en}, 32'h2);
        wr(`SPD_ADDR_AUX, 32'h3, `SPD_RESP_OKAY);
        pins(3'b000);
        chk("supplies", {30'h0, prog_en, spu_en}, 32'h2);
        wr(`SPD_ADDR_AUX, 32'h0, `SPD_RESP_OKAY);
        pins(3'b000);
        chk("supplies", {30'h0, prog_en, spu_en}, 32'h0);
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset();
        t_bidir();
        t_pdir();
        t_fixed();
        t_shared();
        t_aux();
        conclude();
    end
endmodule

// File: rtl/spd_defs.svh
// offsets, field positions, reset values and response codes of the single-wire port driver
`ifndef SPD_DEFS_SVH
`define SPD_DEFS_SVH

// register byte offsets
`define SPD_ADDR_CTRL 4'h0
`define SPD_ADDR_LINE 4'h4
`define SPD_ADDR_AUX 4'h8

// control register fields
`define SPD_CTRL_VAR_LSB 0
`define SPD_CTRL_VAR_MSB 1
`define SPD_CTRL_DIRPOL_BIT 2
`define SPD_CTRL_SHARED_BIT 3

// line register fields
`define SPD_LINE_VALUE_BIT 0
`define SPD_LINE_LEVEL_BIT 1

// auxiliary output fields
`define SPD_AUX_PROG_BIT 0
`define SPD_AUX_SPU_BIT 1

// reset values
`define SPD_CTRL_RST 4'h0
`define SPD_LINE_RST 1'h1
`define SPD_AUX_RST 2'h0

// bus responses
`define SPD_RESP_OKAY 2'h0
`define SPD_RESP_DECERR 2'h3

`endif

// File: rtl/spd_pin_drv.sv
// pin-level driver for the three port variants with one common drive/release/sample view
module spd_pin_drv
    import spd_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // configuration
    input wire spd_variant_type variant,
    input wire logic dir_pol,
    input wire logic shared,
    input wire logic share_busy,
    // common interface: 0 drive low, 1 release
    input wire logic bus_value,
    output logic line_level,
    // bidirectional pin
    input wire logic bid_i,
    output logic bid_o,
    output logic bid_oe,
    // programmable-direction pin
    input wire logic pdir_i,
    output logic pdir_o,
    output logic pdir_oe,
    // fixed-direction pair
    input wire logic fix_i,
    output logic fix_o
);
    logic eff_value;
    logic dir_d;
    logic dir_q;
    logic level_d;

    // a shared pin is let go while the other peripheral owns it
    assign eff_value = bus_value | (shared & share_busy);

    // bidirectional pin: low pulls hard, high leaves it floating
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bid_o <= 1'b0;
            bid_oe <= 1'b0;
        end else begin
            bid_o <= 1'b0;
            bid_oe <= (variant == SPD_VAR_BIDIR) & ~eff_value;
        end
    end

    // direction bit carries the data, polarity-corrected
    always_comb begin
        dir_d = (variant == SPD_VAR_PDIR) ? eff_value : 1'b1;
        if (dir_pol) begin
            dir_d = ~dir_d;
        end
    end

    // data latch is loaded with zero on every edge and never changes
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pdir_o <= 1'b0;
            dir_q <= 1'b0;
            pdir_oe <= 1'b0;
        end else begin
            pdir_o <= 1'b0;
            dir_q <= dir_d;
            pdir_oe <= dir_pol ? dir_d : ~dir_d;
        end
    end

    // fixed output feeds the inverting pulldown stage
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fix_o <= 1'b0;
        end else begin
            fix_o <= (variant == SPD_VAR_FIXED) & ~eff_value;
        end
    end

    // sample the line from the pin that really sees it
    always_comb begin
        case (variant)
            SPD_VAR_BIDIR: level_d = bid_i;
            SPD_VAR_PDIR: level_d = pdir_i;
            SPD_VAR_FIXED: level_d = fix_i;
            default: level_d = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            line_level <= 1'b1;
        end else begin
            line_level <= level_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    AST_BIDIR_DRIVE: assert property ((variant == SPD_VAR_BIDIR) && !eff_value |=> bid_oe && !bid_o)
        else $error("bidirectional pin not pulled low");
    AST_BIDIR_FLOAT: assert property ((variant == SPD_VAR_BIDIR) && eff_value |=> !bid_oe)
        else $error("bidirectional pin not released");
    AST_NEVER_HIGH: assert property (!(bid_oe && bid_o) && !(pdir_oe && pdir_o))
        else $error("line driven high");
    AST_PDIR_OUT: assert property ((variant == SPD_VAR_PDIR) |=> pdir_oe == !$past(eff_value))
        else $error("direction bit does not follow bus value");
    AST_PDIR_DIRBIT: assert property ((variant == SPD_VAR_PDIR) |=> dir_q == ($past(dir_pol) ^ $past(eff_value)))
        else $error("direction bit polarity wrong");
    AST_FIX_INV: assert property ((variant == SPD_VAR_FIXED) |=> fix_o == !$past(eff_value))
        else $error("fixed output not inverted");
    AST_SAMPLE_SRC: assert property ((variant == SPD_VAR_PDIR) |=> line_level == $past(pdir_i))
        else $error("line not sampled from the pin");
    AST_SHARED_REL: assert property (shared && share_busy |=> !bid_oe && !fix_o)
        else $error("shared pin driven while busy");
endmodule

// File: rtl/spd_pkg.sv
// types shared by the single-wire port driver
package spd_pkg;
    // pin variant that carries the shared line
    typedef enum logic [1:0] {
        SPD_VAR_BIDIR,
        SPD_VAR_PDIR,
        SPD_VAR_FIXED,
        SPD_VAR_OFF
    } spd_variant_type;
endpackage

// File: rtl/spd_top.sv
// single-wire port driver with AXI4-Lite register access
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`include "spd_defs.svh"

module spd_top
    import spd_pkg::*;
#(
    parameter int ADDR_W = 4
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // bidirectional pin
    input wire logic bid_i,
    output logic bid_o,
    output logic bid_oe,
    // programmable-direction pin
    input wire logic pdir_i,
    output logic pdir_o,
    output logic pdir_oe,
    // fixed-direction pair, output goes to the inverting pulldown stage
    input wire logic fix_i,
    output logic inverting_pulldown_stage,
    // pin sharing with another peripheral
    input wire logic share_busy,
    // supply controls
    output logic prog_supply_en,
    output logic strong_pullup_en
);
    // register state
    logic [3:0] ctrl_q;
    logic value_q;
    logic [1:0] aux_q;
    logic line_level;

    // write channel state
    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic wr_hit;
    logic wr_lane0;

    // read channel state
    logic rd_hit;
    logic [31:0] rd_word;

    // a write is done once both address and data are held
    assign wr_fire = aw_have_q & w_have_q & ~bvalid;
    assign wr_lane0 = wr_fire & wstrb_q[0];
    assign wr_hit = (awaddr_q == `SPD_ADDR_CTRL) | (awaddr_q == `SPD_ADDR_LINE) | (awaddr_q == `SPD_ADDR_AUX);

    // write address and data are taken in either order
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            awready <= 1'b1;
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_have_q <= 1'b1;
                awaddr_q <= awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end else if (bvalid && bready) begin
                awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wready <= 1'b1;
            w_have_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_have_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end else if (bvalid && bready) begin
                wready <= 1'b1;
            end
        end
    end

    // write response, unmapped offsets answer with a decode error
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bvalid <= 1'b0;
            bresp <= `SPD_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= wr_hit ? `SPD_RESP_OKAY : `SPD_RESP_DECERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // control: variant, direction polarity, shared pin
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `SPD_CTRL_RST;
        end else if (wr_lane0 && awaddr_q == `SPD_ADDR_CTRL) begin
            ctrl_q <= wdata_q[3:0];
        end
    end

    // bus value: reset releases the line so the latch holds one before any sample
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            value_q <= `SPD_LINE_RST;
        end else if (wr_lane0 && awaddr_q == `SPD_ADDR_LINE) begin
            value_q <= wdata_q[`SPD_LINE_VALUE_BIT];
        end
    end

    // supply controls; the strong pull-up is kept off while the programming supply is on
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            aux_q <= `SPD_AUX_RST;
        end else if (wr_lane0 && awaddr_q == `SPD_ADDR_AUX) begin
            aux_q <= wdata_q[1:0];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_supply_en <= 1'b0;
            strong_pullup_en <= 1'b0;
        end else begin
            prog_supply_en <= aux_q[`SPD_AUX_PROG_BIT];
            strong_pullup_en <= aux_q[`SPD_AUX_SPU_BIT] & ~aux_q[`SPD_AUX_PROG_BIT];
        end
    end

    // read decode
    assign rd_hit = (araddr == `SPD_ADDR_CTRL) | (araddr == `SPD_ADDR_LINE) | (araddr == `SPD_ADDR_AUX);

    always_comb begin
        rd_word = 32'h0;
        case (araddr)
            `SPD_ADDR_CTRL: rd_word[3:0] = ctrl_q;
            `SPD_ADDR_LINE: begin
                rd_word[`SPD_LINE_VALUE_BIT] = value_q;
                rd_word[`SPD_LINE_LEVEL_BIT] = line_level;
            end
            `SPD_ADDR_AUX: rd_word[1:0] = aux_q;
            default: rd_word = 32'h0;
        endcase
    end

    // read channel: one read at a time, answer in the cycle after the address
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `SPD_RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= rd_hit ? `SPD_RESP_OKAY : `SPD_RESP_DECERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // pin-level driver
    spd_pin_drv u_pin_drv (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .variant(spd_variant_type'(ctrl_q[`SPD_CTRL_VAR_MSB:`SPD_CTRL_VAR_LSB])),
        .dir_pol(ctrl_q[`SPD_CTRL_DIRPOL_BIT]),
        .shared(ctrl_q[`SPD_CTRL_SHARED_BIT]),
        .share_busy(share_busy),
        .bus_value(value_q),
        .line_level(line_level),
        .bid_i(bid_i),
        .bid_o(bid_o),
        .bid_oe(bid_oe),
        .pdir_i(pdir_i),
        .pdir_o(pdir_o),
        .pdir_oe(pdir_oe),
        .fix_i(fix_i),
        .fix_o(inverting_pulldown_stage)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // a held write is answered on the next edge
    sequence s_wr_held;
        aw_have_q && w_have_q && !bvalid;
    endsequence

    sequence s_line_low_write;
        s_wr_held ##0 (awaddr_q == `SPD_ADDR_LINE) && wstrb_q[0] && !wdata_q[0];
    endsequence

    AST_WR_RESP: assert property (s_wr_held |=> bvalid && !awready && !wready)
        else $error("write not answered");
    AST_LINE_DRIVE: assert property (s_line_low_write ##1 (ctrl_q[1:0] == 2'h0 && !ctrl_q[3]) |=> bid_oe)
        else $error("line write did not drive the pin low");
    AST_PDIR_LATCH: assert property (!pdir_o)
        else $error("direction-variant data latch not zero");
    AST_SPU_INTERLOCK: assert property (prog_supply_en |-> !strong_pullup_en)
        else $error("pull-up on with programming supply");
    AST_RD_RESP: assert property (arvalid && arready |=> (rvalid and (!rready |=> rvalid)))
        else $error("read answer dropped before taken");

    // an answer waits, unchanged, until the master takes it
    sequence s_wr_waiting;
        bvalid && !bready;
    endsequence

    sequence s_rd_waiting;
        rvalid && !rready;
    endsequence

    AST_B_HOLD: assert property (s_wr_waiting |=> bvalid && $stable(bresp))
        else $error("write answer changed before taken");
    AST_R_HOLD: assert property (s_rd_waiting |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer changed before taken");

    // only one write and one read in flight; channels reopen once the answer is taken
    sequence s_rd_taken;
        arvalid && arready;
    endsequence

    sequence s_wr_answered;
        bvalid && bready;
    endsequence

    AST_AW_CLOSED: assert property (bvalid |-> !awready && !wready)
        else $error("write channel open while answer pending");
    AST_AR_CLOSED: assert property (rvalid |-> !arready)
        else $error("read address accepted while answer pending");
    AST_RD_ONE: assert property (s_rd_taken |=> rvalid && !arready)
        else $error("read not answered in the next cycle");
    AST_WR_REOPEN: assert property (s_wr_answered |=> !bvalid && awready && wready)
        else $error("write channels not reopened after answer");

    // unmapped offsets answer with a decode error and leave every register alone
    sequence s_wr_unmapped;
        s_wr_held ##0 !wr_hit;
    endsequence

    sequence s_rd_unmapped;
        s_rd_taken ##0 !rd_hit;
    endsequence

    AST_WR_DECERR: assert property (s_wr_unmapped |=> bresp == `SPD_RESP_DECERR
            && $stable(ctrl_q) && $stable(value_q) && $stable(aux_q))
        else $error("unmapped write not refused");
    AST_RD_DECERR: assert property (s_rd_unmapped |=> rresp == `SPD_RESP_DECERR && rdata == 32'h0)
        else $error("unmapped read not refused");

    // a lane-0 write to the line register lands at the answer edge
    sequence s_line_write;
        s_wr_held ##0 (awaddr_q == `SPD_ADDR_LINE) && wstrb_q[0];
    endsequence

    AST_LINE_LAND: assert property (s_line_write |=> value_q == $past(wdata_q[`SPD_LINE_VALUE_BIT]))
        else $error("line register write lost");

    // supply outputs follow their register one cycle later
    AST_PROG_FOLLOW: assert property (1'b1 |=> prog_supply_en == $past(aux_q[`SPD_AUX_PROG_BIT]))
        else $error("programming supply does not follow its register");
    AST_SPU_FOLLOW: assert property (1'b1 |=> strong_pullup_en ==
            ($past(aux_q[`SPD_AUX_SPU_BIT]) && !$past(aux_q[`SPD_AUX_PROG_BIT])))
        else $error("strong pull-up does not follow its register");
endmodule
